/* design/cmd_buf_pkg.sv */
package cmd_buf_pkg;

  // Command/address word widths
  localparam int ADDR_W      = 16;
  localparam int BANK_W      = 3;
  localparam int CS_MAX      = 4;
  localparam int CKE_W       = 2;
  localparam int ODT_W       = 2;

  // Reset values
  localparam logic       ERR_N_RST    = 1'b1;
  localparam logic       ERR_OE_RST   = 1'b0;
  localparam logic [3:0] CS_OUT_RST   = 4'hF;
  localparam logic       PAR_VLD_RST  = 1'b0;

  // Parity check latency in clock cycles after the command cycle
  localparam int PARITY_LAG_CYC = 1;

  // Command/address group that takes part in parity
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BANK_W-1:0] bank;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
  } cmd_addr_t;

  // Control group kept out of parity
  typedef struct packed {
    logic [CKE_W-1:0] cke;
    logic [ODT_W-1:0] odt;
  } ctl_t;

  localparam int CA_W = $bits(cmd_addr_t);

  function automatic logic parity_of(input cmd_addr_t ca);
    parity_of = ^ca;
  endfunction

endpackage

/* design/parity_checker.sv */
module parity_checker
  import cmd_buf_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  input  wire cmd_addr_t ca_i,
  input  wire logic      cs_hit_i,
  input  wire logic      par_i,
  output logic           err_n_o,
  output logic           err_oe_o
);

  logic calc_r;
  logic calc_nxt;
  logic vld_r;
  logic vld_nxt;
  logic err_n_r;
  logic err_n_nxt;
  logic oe_r;
  logic oe_nxt;

  always_comb begin
    calc_nxt = parity_of(ca_i);
    vld_nxt  = cs_hit_i;
    err_n_nxt = err_n_r;
    oe_nxt    = oe_r;
    if (vld_r && (calc_r != par_i)) begin
      err_n_nxt = 1'b0;
      oe_nxt    = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      calc_r  <= 1'b0;
      vld_r   <= PAR_VLD_RST;
      err_n_r <= ERR_N_RST;
      oe_r    <= ERR_OE_RST;
    end else begin
      calc_r  <= calc_nxt;
      vld_r   <= vld_nxt;
      err_n_r <= err_n_nxt;
      oe_r    <= oe_nxt;
    end
  end

  assign err_n_o  = err_n_r;
  assign err_oe_o = oe_r;

endmodule

/* design/registered_cmd_addr_buffer_parity.sv */
// Functional notes
// - Capture all inputs on the rising edge of the true clock.
// - Quad select off: two chip selects, each driven to two output copies.
// - Quad select on: four chip selects, one output each.
// - Each captured word is redriven or used as a control register access.
// - Fan out all bits to two copies; alternate mode passes four bits 1:1.
// - Computed parity is the LSB of the sum of command/address bits.
// - Parity mismatch pulls the open-drain error output low.
// - Clock enables, termination controls and chip selects excluded from parity.
// - Parity checked only on cycles with an asserted chip select.
// - Back-side mounting keeps input bus termination enabled on every input.
// - Unused outputs may be disabled to stop toggling.
module registered_cmd_addr_buffer_parity
  import cmd_buf_pkg::*;
(
  // Clock and reset
  input  wire logic              REF_CLK_I,
  input  wire logic              RST_N_I,
  // Mode straps
  input  wire logic              QUAD_SELECT_ENABLE_N_I,
  input  wire logic              BACK_SIDE_MOUNT_I,
  input  wire logic              ONE_TO_ONE_MODE_I,
  input  wire logic              COPY_B_DISABLE_I,
  input  wire logic              TERM_DISABLE_REQ_I,
  // Command/address inputs
  input  wire cmd_addr_t         CA_I,
  input  wire ctl_t              CTL_I,
  input  wire logic [CS_MAX-1:0] CHIP_SELECT_IN_N_I,
  input  wire logic              PARITY_IN_I,
  input  wire logic              CFG_ACCESS_I,
  // Copy A outputs
  output cmd_addr_t              CA_A_O,
  output ctl_t                   CTL_A_O,
  output logic [1:0]             CHIP_SELECT_OUT_COPY_A_N_O,
  // Copy B outputs
  output cmd_addr_t              CA_B_O,
  output ctl_t                   CTL_B_O,
  output logic [1:0]             CHIP_SELECT_OUT_COPY_B_N_O,
  // Quad select outputs
  output logic [CS_MAX-1:0]      CHIP_SELECT_OUT_N_O,
  // Control register access
  output logic                   CFG_WR_O,
  output cmd_addr_t              CFG_DATA_O,
  // Termination and error
  output logic                   INPUT_BUS_TERMINATION_O,
  output logic                   PARITY_ERROR_OUT_N_O,
  output logic                   PARITY_ERROR_OUT_OE_O
);

  // Straps come from pins: two-flop synchronisers
  logic [4:0] strap_s1_r;
  logic [4:0] strap_s2_r;
  logic       quad_n;
  logic       back_side_mount;
  logic       one_to_one;
  logic       b_off;
  logic       term_off_req;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      strap_s1_r <= 5'h01;
      strap_s2_r <= 5'h01;
    end else begin
      strap_s1_r <= {TERM_DISABLE_REQ_I, COPY_B_DISABLE_I, ONE_TO_ONE_MODE_I,
                     BACK_SIDE_MOUNT_I, QUAD_SELECT_ENABLE_N_I};
      strap_s2_r <= strap_s1_r;
    end
  end

  assign quad_n       = strap_s2_r[0];
  assign back_side_mount       = strap_s2_r[1];
  assign one_to_one   = strap_s2_r[2];
  assign b_off        = strap_s2_r[3];
  assign term_off_req = strap_s2_r[4];

  // Input capture: on-board bus assumed aligned to the reference clock
  cmd_addr_t         ca_r;
  ctl_t              ctl_r;
  logic [CS_MAX-1:0] cs_r;
  logic              cfg_r;
  cmd_addr_t         ca_nxt;
  ctl_t              ctl_nxt;
  logic [CS_MAX-1:0] cs_nxt;
  logic              cfg_nxt;
  logic              cs_hit;

  always_comb begin
    ca_nxt  = CA_I;
    ctl_nxt = CTL_I;
    cs_nxt  = CHIP_SELECT_IN_N_I;
    cfg_nxt = CFG_ACCESS_I;
    if (quad_n) begin
      cs_nxt[3:2] = 2'h3;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ca_r  <= '0;
      ctl_r <= '0;
      cs_r  <= CS_OUT_RST;
      cfg_r <= 1'b0;
    end else begin
      ca_r  <= ca_nxt;
      ctl_r <= ctl_nxt;
      cs_r  <= cs_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  assign cs_hit = ~&cs_r;

  // Output stage
  cmd_addr_t         ca_a_r;
  cmd_addr_t         ca_b_r;
  ctl_t              ctl_a_r;
  ctl_t              ctl_b_r;
  logic [1:0]        csa_r;
  logic [1:0]        csb_r;
  logic [CS_MAX-1:0] csq_r;
  logic              cfg_wr_r;
  cmd_addr_t         cfg_data_r;
  logic              ibt_r;
  cmd_addr_t         ca_a_nxt;
  cmd_addr_t         ca_b_nxt;
  ctl_t              ctl_a_nxt;
  ctl_t              ctl_b_nxt;
  logic [1:0]        csa_nxt;
  logic [1:0]        csb_nxt;
  logic [CS_MAX-1:0] csq_nxt;
  logic              cfg_wr_nxt;
  cmd_addr_t         cfg_data_nxt;
  logic              ibt_nxt;

  always_comb begin
    ca_a_nxt     = ca_a_r;
    ca_b_nxt     = ca_b_r;
    ctl_a_nxt    = ctl_a_r;
    ctl_b_nxt    = ctl_b_r;
    csa_nxt      = 2'h3;
    csb_nxt      = 2'h3;
    csq_nxt      = CS_OUT_RST;
    cfg_wr_nxt   = 1'b0;
    cfg_data_nxt = cfg_data_r;
    if (cfg_r && cs_hit) begin
      cfg_wr_nxt   = 1'b1;
      cfg_data_nxt = ca_r;
    end else begin
      ca_a_nxt  = ca_r;
      ctl_a_nxt = ctl_r;
      if (!b_off) begin
        ca_b_nxt  = ca_r;
        ctl_b_nxt = ctl_r;
      end
      if (one_to_one) begin
        ctl_b_nxt = ctl_b_r;
      end
      if (quad_n) begin
        csa_nxt = cs_r[1:0];
        csb_nxt = b_off ? 2'h3 : cs_r[1:0];
      end else begin
        csq_nxt = cs_r;
      end
    end
    ibt_nxt = back_side_mount | ~term_off_req;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ca_a_r     <= '0;
      ca_b_r     <= '0;
      ctl_a_r    <= '0;
      ctl_b_r    <= '0;
      csa_r      <= 2'h3;
      csb_r      <= 2'h3;
      csq_r      <= CS_OUT_RST;
      cfg_wr_r   <= 1'b0;
      cfg_data_r <= '0;
      ibt_r      <= 1'b1;
    end else begin
      ca_a_r     <= ca_a_nxt;
      ca_b_r     <= ca_b_nxt;
      ctl_a_r    <= ctl_a_nxt;
      ctl_b_r    <= ctl_b_nxt;
      csa_r      <= csa_nxt;
      csb_r      <= csb_nxt;
      csq_r      <= csq_nxt;
      cfg_wr_r   <= cfg_wr_nxt;
      cfg_data_r <= cfg_data_nxt;
      ibt_r      <= ibt_nxt;
    end
  end

  // Parity pin: same-clock source assumed, one stage aligns it with calc_r in the checker
  logic par_r;
  logic par_nxt;

  always_comb begin
    par_nxt = PARITY_IN_I;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      par_r <= 1'b0;
    end else begin
      par_r <= par_nxt;
    end
  end

  parity_checker u_parity (
    .clk_i    (REF_CLK_I),
    .rst_n_i  (RST_N_I),
    .ca_i     (ca_r),
    .cs_hit_i (cs_hit),
    .par_i    (par_r),
    .err_n_o  (PARITY_ERROR_OUT_N_O),
    .err_oe_o (PARITY_ERROR_OUT_OE_O)
  );

  assign CA_A_O                     = ca_a_r;
  assign CA_B_O                     = ca_b_r;
  assign CTL_A_O                    = ctl_a_r;
  assign CTL_B_O                    = ctl_b_r;
  assign CHIP_SELECT_OUT_COPY_A_N_O = csa_r;
  assign CHIP_SELECT_OUT_COPY_B_N_O = csb_r;
  assign CHIP_SELECT_OUT_N_O        = csq_r;
  assign CFG_WR_O                   = cfg_wr_r;
  assign CFG_DATA_O                 = cfg_data_r;
  assign INPUT_BUS_TERMINATION_O    = ibt_r;

endmodule

/* tb/cmd_buf_assertions.sv */
module cmd_buf_assertions
  import cmd_buf_pkg::*;
(
  // Inputs of the block
  input wire logic       REF_CLK_I,
  input wire logic       RST_N_I,
  input wire logic       QUAD_SELECT_ENABLE_N_I,
  input wire logic       BACK_SIDE_MOUNT_I,
  input wire logic       COPY_B_DISABLE_I,
  input wire logic       TERM_DISABLE_REQ_I,
  input wire cmd_addr_t  CA_I,
  input wire logic [3:0] CHIP_SELECT_IN_N_I,
  input wire logic       PARITY_IN_I,
  input wire logic       CFG_ACCESS_I,
  // Outputs watched
  input wire cmd_addr_t  CA_A_O,
  input wire cmd_addr_t  CA_B_O,
  input wire logic [1:0] CHIP_SELECT_OUT_COPY_A_N_O,
  input wire logic [3:0] CHIP_SELECT_OUT_N_O,
  input wire logic       CFG_WR_O,
  input wire logic       INPUT_BUS_TERMINATION_O,
  input wire logic       PARITY_ERROR_OUT_N_O,
  input wire logic       PARITY_ERROR_OUT_OE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire sel = CHIP_SELECT_IN_N_I[1:0] != 2'h3;
  sequence s_bad_par;
    sel ##1 (PARITY_IN_I != ^$past(CA_I));
  endsequence
  a_redrive_lag: assert property (
    sel && !CFG_ACCESS_I |-> ##2 CA_A_O == $past(CA_I, 2)) else $error("copy A word wrong");
  a_dual_sel: assert property (
    QUAD_SELECT_ENABLE_N_I[*4] ##0 !CFG_ACCESS_I |-> ##2 CHIP_SELECT_OUT_N_O == 4'hF
    && CHIP_SELECT_OUT_COPY_A_N_O == $past(CHIP_SELECT_IN_N_I[1:0], 2)) else $error("dual sel");
  a_quad_sel: assert property (
    (!QUAD_SELECT_ENABLE_N_I)[*4] ##0 !CFG_ACCESS_I |->
    ##2 CHIP_SELECT_OUT_N_O == $past(CHIP_SELECT_IN_N_I, 2)) else $error("quad sel");
  a_cfg_pulse: assert property (
    sel |-> ##2 CFG_WR_O == $past(CFG_ACCESS_I, 2)) else $error("cfg write wrong");
  a_copy_b_match: assert property (
    (!COPY_B_DISABLE_I)[*4] |-> CA_B_O == CA_A_O) else $error("copy B differs");
  a_copy_b_hold: assert property (
    COPY_B_DISABLE_I[*4] |-> $stable(CA_B_O)) else $error("copy B toggles");
  a_par_err: assert property (
    s_bad_par |-> ##[1:2] !PARITY_ERROR_OUT_N_O) else $error("mismatch not flagged");
  a_err_sticky: assert property (
    !PARITY_ERROR_OUT_N_O |=> !PARITY_ERROR_OUT_N_O) else $error("error released");
  a_err_oe: assert property (
    PARITY_ERROR_OUT_OE_O == !PARITY_ERROR_OUT_N_O) else $error("enable and level differ");
  a_ibt_kept: assert property (
    (BACK_SIDE_MOUNT_I || !TERM_DISABLE_REQ_I)[*4] |-> INPUT_BUS_TERMINATION_O)
    else $error("termination off");
endmodule

bind registered_cmd_addr_buffer_parity cmd_buf_assertions u_chk (.*);

/* tb/cmd_host.sv */
module cmd_host
  import cmd_buf_pkg::*;
(
  // Clock
  input  wire logic clk_i,
  // Command bus
  output cmd_addr_t  ca_o,
  output ctl_t       ctl_o,
  output logic [3:0] cs_n_o,
  output logic       cfg_o,
  output logic       par_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic par_nxt = 1'b0;
  initial begin
    {ca_o, ctl_o, cfg_o, par_o} = '0;
    cs_n_o = 4'hF;
  end
  task automatic cycle(input cmd_addr_t w, input logic [3:0] s, input logic c, input logic bad);
    @(negedge clk_i);
    par_o = par_nxt;
    par_nxt = ^w ^ bad;
    ca_o = w;
    ctl_o = ~ctl_o;
    cs_n_o = s;
    cfg_o = c;
  endtask
endmodule

/* tb/registered_cmd_addr_buffer_parity_bench.sv */
module registered_cmd_addr_buffer_parity_bench
  import cmd_buf_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst_n, quad_n, mount, one2one, b_off, term_off, par, cfg, cfg_wr, input_bus_termination;
  logic       err_n, err_oe;
  cmd_addr_t  ca, ca_a, ca_b, cfg_d;
  ctl_t       ctl, ctl_a, ctl_b;
  logic [3:0] cs_n, cs_q;
  logic [1:0] cs_a, cs_b;
  int         fails = 0, compares = 0, cyc = 0;
  cmd_host u_host (.clk_i(clk), .ca_o(ca), .ctl_o(ctl), .cs_n_o(cs_n), .cfg_o(cfg), .par_o(par));
  registered_cmd_addr_buffer_parity u_dut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .QUAD_SELECT_ENABLE_N_I(quad_n),
    .BACK_SIDE_MOUNT_I(mount), .ONE_TO_ONE_MODE_I(one2one), .COPY_B_DISABLE_I(b_off),
    .TERM_DISABLE_REQ_I(term_off), .CA_I(ca), .CTL_I(ctl), .CHIP_SELECT_IN_N_I(cs_n),
    .PARITY_IN_I(par), .CFG_ACCESS_I(cfg), .CA_A_O(ca_a), .CTL_A_O(ctl_a), .CA_B_O(ca_b),
    .CHIP_SELECT_OUT_COPY_A_N_O(cs_a), .CTL_B_O(ctl_b), .CHIP_SELECT_OUT_COPY_B_N_O(cs_b),
    .CHIP_SELECT_OUT_N_O(cs_q), .CFG_WR_O(cfg_wr), .CFG_DATA_O(cfg_d),
    .INPUT_BUS_TERMINATION_O(input_bus_termination), .PARITY_ERROR_OUT_N_O(err_n), .PARITY_ERROR_OUT_OE_O(err_oe));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk_w(input string n, input cmd_addr_t e, input cmd_addr_t g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic chk_b(input string n, input logic [3:0] e, input logic [3:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Straps go through a synchroniser
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask
  task automatic send(input cmd_addr_t w, input logic [3:0] s, input logic c, input logic bad);
    u_host.cycle(w, s, c, bad);
    u_host.cycle(~w, 4'hF, 1'b0, 1'b0);
    @(negedge clk);
  endtask
  task automatic t_dual;
    send(22'h2A5A5A, 4'hE, 1'b0, 1'b0);
    chk_w("copy a", 22'h2A5A5A, ca_a);
    chk_w("copy b", 22'h2A5A5A, ca_b);
    chk_b("sel a", 4'h2, 4'(cs_a));
    chk_b("sel b", 4'h2, 4'(cs_b));
    chk_b("sel q", 4'hF, cs_q);
    chk_b("ctl a", 4'hF, ctl_a);
    chk_b("ctl b", 4'hF, ctl_b);
    $display("dual select done");
  endtask
  // Control bits alternate each host cycle; copy B keeps the last one
  task automatic t_one_to_one;
    one2one = 1'b1;
    settle;
    send(22'h2A5A5A, 4'hE, 1'b0, 1'b0);
    chk_b("ctl a", 4'hF, ctl_a);
    chk_b("ctl b", 4'h0, ctl_b);
    one2one = 1'b0;
    settle;
    $display("one to one done");
  endtask
  task automatic t_quad;
    quad_n = 1'b0;
    settle;
    send(22'h15A5A5, 4'h7, 1'b0, 1'b0);
    chk_b("sel q", 4'h7, cs_q);
    chk_b("sel a", 4'h3, 4'(cs_a));
    quad_n = 1'b1;
    settle;
    $display("quad select done");
  endtask
  task automatic t_cfg;
    send(22'h000F0F, 4'hE, 1'b1, 1'b0);
    chk_b("cfg wr", 4'h1, 4'(cfg_wr));
    chk_w("cfg data", 22'h000F0F, cfg_d);
    chk_w("copy a", 22'h2A5A5A, ca_a);
    @(negedge clk);
    chk_b("cfg wr", 4'h0, 4'(cfg_wr));
    $display("control access done");
  endtask
  task automatic t_power;
    b_off = 1'b1;
    settle;
    send(22'h3C3C3C, 4'hD, 1'b0, 1'b0);
    chk_w("copy b", 22'h3FF0F0, ca_b);
    chk_w("copy a", 22'h3C3C3C, ca_a);
    {b_off, mount, term_off} = 3'h3;
    settle;
    chk_b("ibt", 4'h1, 4'(input_bus_termination));
    mount = 1'b0;
    settle;
    chk_b("ibt", 4'h0, 4'(input_bus_termination));
    term_off = 1'b0;
    $display("power and mount done");
  endtask
  task automatic t_parity;
    cmd_addr_t w[3] = '{22'h000001, 22'h3FFFFF, 22'h123456};
    foreach (w[i]) send(w[i], 4'hD, 1'b0, 1'b0);
    u_host.cycle(22'h000007, 4'hF, 1'b0, 1'b1);
    send(22'h000000, 4'hF, 1'b0, 1'b0);
    chk_b("err", 4'h1, 4'(err_n));
    send(22'h000003, 4'hE, 1'b0, 1'b1);
    @(negedge clk);
    chk_b("err", 4'h0, 4'(err_n));
    chk_b("err oe", 4'h1, 4'(err_oe));
    $display("parity done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      complete_run;
    end
  end
  initial begin
    {quad_n, mount, one2one, b_off, term_off, rst_n} = 6'h20;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    settle;
    chk_b("err", 4'h1, 4'(err_n));
    chk_b("err oe", 4'h0, 4'(err_oe));
    t_dual;
    t_one_to_one;
    t_quad;
    t_cfg;
    t_power;
    t_parity;
    complete_run;
  end
endmodule
